/* File: src/lsi_pkg.sv */
// constants, field layout and carrier types for the line status block
package lsi_pkg;

   localparam int         LSI_CHANNELS      = 2;

   // register offsets of the first channel, second channel adds the stride
   localparam logic [7:0] LSI_OFF_LIVE_A    = 8'h16;
   localparam logic [7:0] LSI_OFF_LIVE_B    = 8'h17;
   localparam logic [7:0] LSI_OFF_EVT_LATCH = 8'h18;
   localparam logic [7:0] LSI_CH_STRIDE     = 8'h20;

   // bit positions shared by live A and the latched register, then the live B fields
   localparam int         LSI_BIT_EQ        = 7;
   localparam int         LSI_BIT_IBLA      = 6;
   localparam int         LSI_BIT_IBLD      = 5;
   localparam int         LSI_BIT_PSYNC     = 4;
   localparam int         LSI_BIT_TXCLK     = 3;
   localparam int         LSI_BIT_DRVF      = 2;
   localparam int         LSI_BIT_ALARM     = 1;
   localparam int         LSI_BIT_SLOSS     = 0;
   localparam int         LSI_BIT_RLOOP     = 5;
   localparam int         LSI_ATT_LSB       = 0;
   localparam int         LSI_ATT_W         = 5;

   // values after reset
   localparam logic [7:0] LSI_LIVE_RST      = 8'h00;
   localparam logic [7:0] LSI_LATCH_RST     = 8'h00;
   localparam logic [7:0] LSI_RD_RST        = 8'h00;
   localparam logic [1:0] LSI_RSVD_B        = 2'h0;

   // timing
   localparam int         LSI_CLK_HZ        = 20_000_000;
   localparam int         LSI_TXCLK_IDLE    = 70;
   localparam int         LSI_IDLE_W        = 7;
   localparam int         LSI_ACT_SHORT_MS  = 40;
   localparam int         LSI_ACT_LONG_MS   = 5100;
   localparam int         LSI_ACT_SHORT_CYC = LSI_ACT_SHORT_MS
                                              * (LSI_CLK_HZ / 1000);
   localparam int         LSI_ACT_LONG_CYC  = LSI_ACT_LONG_MS
                                              * (LSI_CLK_HZ / 1000);
   localparam int         LSI_ACT_CNT_W     = 27;

   typedef struct packed {
      logic                 eq_out_of_range;
      logic                 inband_activate_code;
      logic                 inband_deactivate_flag;
      logic                 pattern_sync_flag;
      logic                 driver_fault_flag;
      logic                 alarm_pattern_flag;
      logic                 signal_loss_flag;
      logic                 remote_loop_active;
      logic [LSI_ATT_W-1:0] line_attenuation_code;
   } lsi_det_t;

   typedef struct packed {
      logic [7:0] mask;
      logic [7:0] edge_select;
   } lsi_irq_cfg_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } lsi_rd_rsp_t;

endpackage : lsi_pkg

/* File: src/lsi_status_top.sv */
// per-channel line status, event latches and host read port
`timescale 1ns/1ps

module lsi_status_top
   import lsi_pkg::*;
#(
   parameter int ACT_SHORT_CYCLES = LSI_ACT_SHORT_CYC,
   parameter int ACT_LONG_CYCLES  = LSI_ACT_LONG_CYC
) (
   input  wire logic                            ref_clk,
   input  wire logic                            reset,
   input  wire logic [7:0]                      host_addr,
   input  wire logic                            host_rd,
   input  wire lsi_det_t     [LSI_CHANNELS-1:0] det,
   input  wire lsi_irq_cfg_t [LSI_CHANNELS-1:0] irq_cfg,
   input  wire logic         [LSI_CHANNELS-1:0] auto_remote_loop_enable,
   input  wire logic         [LSI_CHANNELS-1:0] tx_clk_pin,
   output lsi_rd_rsp_t                          rd_rsp,
   output logic                                 interrupt_request
);

   localparam logic [LSI_ACT_CNT_W-1:0] ACT_SHORT_LIM =
      LSI_ACT_CNT_W'(ACT_SHORT_CYCLES);
   localparam logic [LSI_ACT_CNT_W-1:0] ACT_LONG_LIM  =
      LSI_ACT_CNT_W'(ACT_LONG_CYCLES);
   localparam logic [LSI_IDLE_W-1:0]    IDLE_LIM      =
      LSI_IDLE_W'(LSI_TXCLK_IDLE);

   logic [7:0]              ch_rd_data   [LSI_CHANNELS];
   logic [LSI_CHANNELS-1:0] ch_any_event;

   logic [7:0]              nxt_rd_data;
   logic                    nxt_irq;
   lsi_rd_rsp_t             rd_rsp_ff;
   logic                    irq_ff;

   genvar c;
   generate
      for (c = 0; c < LSI_CHANNELS; c++) begin : g_ch
         localparam logic [7:0] BASE_OFF = 8'(c * LSI_CH_STRIDE);

         // tx clock pin is asynchronous: two stages before any use
         logic                     tclk_s1_ff;
         logic                     tclk_s2_ff;
         logic                     tclk_s3_ff;
         logic                     tclk_toggle;
         logic [LSI_IDLE_W-1:0]    idle_cnt_ff;
         logic [LSI_IDLE_W-1:0]    nxt_idle_cnt;
         logic                     tx_clock_loss_flag;

         logic [LSI_ACT_CNT_W-1:0] act_cnt_ff;
         logic [LSI_ACT_CNT_W-1:0] nxt_act_cnt;
         logic [LSI_ACT_CNT_W-1:0] act_lim;
         logic                     inband_activate_flag;

         logic [7:0]               live_now;
         logic [7:0]               live_a_ff;
         logic [7:0]               live_b_ff;
         logic [7:0]               nxt_live_b;
         logic [7:0]               rise;
         logic [7:0]               fall;
         logic [7:0]               event_now;
         logic [7:0]               latch_ff;
         logic [7:0]               nxt_latch;

         logic                     hit_live_a;
         logic                     hit_live_b;
         logic                     hit_latch;
         logic                     clr_latch;

         // tx clock loss detection
         logic                     idle_sat;

         assign tclk_toggle = tclk_s2_ff ^ tclk_s3_ff;
         assign idle_sat    = idle_cnt_ff > IDLE_LIM;

         always_comb begin
            if (tclk_toggle) begin
               nxt_idle_cnt = '0;
            end else if (idle_sat) begin
               // hold one past the limit so a dead clock never wraps
               nxt_idle_cnt = idle_cnt_ff;
            end else begin
               nxt_idle_cnt = idle_cnt_ff + 1'b1;
            end
         end

         assign tx_clock_loss_flag = idle_sat;

         // no reset on the stages, they settle while reset is held
         always_ff @(posedge ref_clk) begin
            tclk_s1_ff <= tx_clk_pin[c];
         end

         always_ff @(posedge ref_clk) begin
            tclk_s2_ff <= tclk_s1_ff;
         end

         // edge memory reads only the settled second stage
         always_ff @(posedge ref_clk) begin
            tclk_s3_ff <= tclk_s2_ff;
         end

         always_ff @(posedge ref_clk) begin
            if (reset) begin
               idle_cnt_ff <= '0;
            end else begin
               idle_cnt_ff <= nxt_idle_cnt;
            end
         end

         // activate code must persist beyond the qualifying window
         logic                     act_sat;

         assign act_lim = auto_remote_loop_enable[c] ? ACT_LONG_LIM
                                                     : ACT_SHORT_LIM;
         assign act_sat = act_cnt_ff > act_lim;

         always_comb begin
            if (!det[c].inband_activate_code) begin
               // any gap in the code restarts the window
               nxt_act_cnt = '0;
            end else if (act_sat) begin
               nxt_act_cnt = act_cnt_ff;
            end else begin
               nxt_act_cnt = act_cnt_ff + 1'b1;
            end
         end

         assign inband_activate_flag = act_sat;

         always_ff @(posedge ref_clk) begin
            if (reset) begin
               act_cnt_ff <= '0;
            end else begin
               act_cnt_ff <= nxt_act_cnt;
            end
         end

         // live status each cycle, from the detectors and the two qualifying counters
         always_comb begin
            live_now                = LSI_LIVE_RST;
            live_now[LSI_BIT_EQ]    = det[c].eq_out_of_range;
            live_now[LSI_BIT_IBLA]  = inband_activate_flag;
            live_now[LSI_BIT_IBLD]  = det[c].inband_deactivate_flag;
            live_now[LSI_BIT_PSYNC] = det[c].pattern_sync_flag;
            live_now[LSI_BIT_TXCLK] = tx_clock_loss_flag;
            live_now[LSI_BIT_DRVF]  = det[c].driver_fault_flag;
            live_now[LSI_BIT_ALARM] = det[c].alarm_pattern_flag;
            live_now[LSI_BIT_SLOSS] = det[c].signal_loss_flag;
         end

         always_comb begin
            nxt_live_b = LSI_LIVE_RST;
            nxt_live_b[7:6] = LSI_RSVD_B;
            nxt_live_b[LSI_BIT_RLOOP] = det[c].remote_loop_active;
            nxt_live_b[LSI_ATT_LSB +: LSI_ATT_W] =
               det[c].line_attenuation_code;
         end

         // live registers only track, reads never alter them
         always_ff @(posedge ref_clk) begin
            if (reset) begin
               live_a_ff <= LSI_LIVE_RST;
            end else begin
               live_a_ff <= live_now;
            end
         end

         always_ff @(posedge ref_clk) begin
            if (reset) begin
               live_b_ff <= LSI_LIVE_RST;
            end else begin
               live_b_ff <= nxt_live_b;
            end
         end

         // event qualification, one slice per status bit
         for (genvar b = 0; b < 8; b++) begin : g_bit
            assign rise[b]      = live_now[b] & ~live_a_ff[b];
            assign fall[b]      = ~live_now[b] & live_a_ff[b];
            assign event_now[b] = ~irq_cfg[c].mask[b]
                                  & (rise[b]
                                     | (irq_cfg[c].edge_select[b]
                                        & fall[b]));
         end

         // address decode for this channel
         localparam logic [7:0] LIVE_A_ADR = LSI_OFF_LIVE_A + BASE_OFF;
         localparam logic [7:0] LIVE_B_ADR = LSI_OFF_LIVE_B + BASE_OFF;
         localparam logic [7:0] LATCH_ADR  = LSI_OFF_EVT_LATCH + BASE_OFF;

         assign hit_live_a = host_addr == LIVE_A_ADR;
         assign hit_live_b = host_addr == LIVE_B_ADR;
         assign hit_latch  = host_addr == LATCH_ADR;
         assign clr_latch  = host_rd & hit_latch;

         // set wins over the read clear so no event slips away
         logic [7:0]               kept_latch;

         assign kept_latch = clr_latch ? 8'h00 : latch_ff;

         always_comb begin
            nxt_latch = kept_latch;
            for (int k = 0; k < 8; k++) begin
               if (event_now[k]) begin
                  nxt_latch[k] = 1'b1;
               end
            end
         end

         always_ff @(posedge ref_clk) begin
            if (reset) begin
               latch_ff <= LSI_LATCH_RST;
            end else begin
               latch_ff <= nxt_latch;
            end
         end

         // request looks ahead so it drops on the clearing edge
         assign ch_any_event[c] = |nxt_latch;

         assign ch_rd_data[c] =
            hit_live_a ? live_a_ff :
            hit_live_b ? live_b_ff :
            hit_latch  ? latch_ff  :
                         LSI_RD_RST;
      end
   endgenerate

   // unmapped addresses read zero
   always_comb begin
      nxt_rd_data = LSI_RD_RST;
      for (int i = 0; i < LSI_CHANNELS; i++) begin
         nxt_rd_data = nxt_rd_data | ch_rd_data[i];
      end
   end

   // request follows the latches, so it drops on the clearing read
   assign nxt_irq = |ch_any_event;

   // data returns to zero between reads
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rd_rsp_ff.valid <= 1'b0;
         rd_rsp_ff.data  <= LSI_RD_RST;
      end else begin
         rd_rsp_ff.valid <= host_rd;
         rd_rsp_ff.data  <= host_rd ? nxt_rd_data : LSI_RD_RST;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   assign rd_rsp            = rd_rsp_ff;
   assign interrupt_request = irq_ff;

endmodule : lsi_status_top

/* File: testbench/lsi_status_top_sva.sv */
// port assertions for the line status block
`timescale 1ns/1ps
module lsi_status_top_sva
   import lsi_pkg::*;
#(
   parameter int ACT_SHORT_CYCLES = LSI_ACT_SHORT_CYC,
   parameter int ACT_LONG_CYCLES  = LSI_ACT_LONG_CYC
) (
   input wire logic                            ref_clk,
   input wire logic                            reset,
   input wire logic [7:0]                      host_addr,
   input wire logic                            host_rd,
   input wire lsi_det_t     [LSI_CHANNELS-1:0] det,
   input wire lsi_irq_cfg_t [LSI_CHANNELS-1:0] irq_cfg,
   input wire logic         [LSI_CHANNELS-1:0] auto_remote_loop_enable,
   input wire logic         [LSI_CHANNELS-1:0] tx_clk_pin,
   input wire lsi_rd_rsp_t                     rd_rsp,
   input wire logic                            interrupt_request
);
   wire rd16 = host_rd && host_addr == 8'h16;
   wire rd17 = host_rd && host_addr == 8'h17;
   wire rd18 = host_rd && host_addr == 8'h18;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   rd_answer_a: assert property (
      host_rd |=> rd_rsp.valid) else $error("read not answered");
   rd_idle_a: assert property (
      !host_rd |=> rd_rsp == '0) else $error("answer without read");
   unmapped_a: assert property (
      host_rd && host_addr == 8'h19 |=> rd_rsp.data == 8'h00)
      else $error("unmapped read not zero");
   live_a_a: assert property (
      rd16 && !$past(reset) |=> rd_rsp.data[2:0] ==
      {$past(det[0].driver_fault_flag, 2), $past(det[0].alarm_pattern_flag, 2),
       $past(det[0].signal_loss_flag, 2)}) else $error("live a wrong");
   live_b_a: assert property (
      rd17 && !$past(reset) |=> rd_rsp.data == {2'h0,
      $past(det[0].remote_loop_active, 2),
      $past(det[0].line_attenuation_code, 2)}) else $error("live b wrong");
   rise_irq_a: assert property (
      !irq_cfg[0].mask[0] && $rose(det[0].signal_loss_flag)
      |=> interrupt_request) else $error("rise gave no request");
   fall_irq_a: assert property (
      !$past(reset) && !irq_cfg[0].mask[1] && irq_cfg[0].edge_select[1]
      && $fell(det[0].alarm_pattern_flag) |=> interrupt_request)
      else $error("fall gave no request");
   irq_hold_a: assert property (
      interrupt_request && !host_rd |=> interrupt_request)
      else $error("request dropped without read");
   // timed bits 6 and 3 may fire on their own, so they are left out
   read_clear_a: assert property (
      rd18 && !$past(reset) && $stable(det[0]) ##1 rd18
      |=> (rd_rsp.data & 8'hb7) == 8'h00) else $error("latch not cleared");
   cover property (rd18 ##1 rd_rsp.data != 8'h00);
   cover property ($fell(det[0].alarm_pattern_flag) ##1 interrupt_request);
   cover property ($fell(interrupt_request));
endmodule : lsi_status_top_sva

bind lsi_status_top lsi_status_top_sva #(
   .ACT_SHORT_CYCLES(ACT_SHORT_CYCLES), .ACT_LONG_CYCLES(ACT_LONG_CYCLES))
   sva_u (.ref_clk, .reset, .host_addr, .host_rd, .det, .irq_cfg,
   .auto_remote_loop_enable, .tx_clk_pin, .rd_rsp, .interrupt_request);

/* File: testbench/tb_lsi_status_top.sv */
// self-checking bench for the line status block
`timescale 1ns/1ps
module tb_lsi_status_top
   import lsi_pkg::*;
;
   localparam int SHORT_CYC = 10;
   localparam int LONG_CYC  = 20;
   logic                            ref_clk;
   logic                            reset     = 1'b1;
   logic                            host_rd   = 1'b0;
   logic         [7:0]              host_addr = 8'h00;
   lsi_det_t     [LSI_CHANNELS-1:0] det       = '0;
   lsi_irq_cfg_t [LSI_CHANNELS-1:0] irq_cfg   = '0;
   logic         [LSI_CHANNELS-1:0] auto_remote_loop_enable = 2'h0;
   logic         [LSI_CHANNELS-1:0] tx_clk_pin = 2'h0;
   logic         [LSI_CHANNELS-1:0] tx_run     = 2'h3;
   lsi_rd_rsp_t                     rd_rsp;
   logic                            interrupt_request;
   int                              n_errors = 0, samples_checked = 0, cyc = 0;

   lsi_status_top #(.ACT_SHORT_CYCLES(SHORT_CYC), .ACT_LONG_CYCLES(LONG_CYC))
   dut_u (.ref_clk, .reset, .host_addr, .host_rd, .det, .irq_cfg,
      .auto_remote_loop_enable, .tx_clk_pin, .rd_rsp, .interrupt_request);

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // tx clocks run from time zero, else loss would flag after reset
   always @(negedge ref_clk) begin
      tx_clk_pin <= tx_clk_pin ^ tx_run;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one read, answer judged the cycle after it is taken
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      host_addr = a;
      host_rd = 1'b1;
      @(negedge ref_clk);
      host_rd = 1'b0;
      chk({rd_rsp.valid, rd_rsp.data}, {1'b1, exp});
   endtask : rd_chk

   task automatic irq_chk(input logic exp);
      chk({8'h00, interrupt_request}, {8'h00, exp});
   endtask : irq_chk

   task automatic t_reset_vals;
      logic [7:0] adr [7] = '{8'h16, 8'h17, 8'h18, 8'h36, 8'h37, 8'h38, 8'h19};
      foreach (adr[i]) rd_chk(adr[i], 8'h00);
      irq_chk(1'b0);
   endtask : t_reset_vals

   task automatic t_live;
      det[1] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 5'h15};
      rd_chk(8'h36, 8'hb7);
      rd_chk(8'h37, 8'h35);
      rd_chk(8'h16, 8'h00);
      irq_chk(1'b1);
      rd_chk(8'h38, 8'hb7);
      irq_chk(1'b0);
      rd_chk(8'h36, 8'hb7);
      det[1].line_attenuation_code = 5'h1f;
      rd_chk(8'h37, 8'h3f);
      det[1] = '0;
      rd_chk(8'h38, 8'h00);
   endtask : t_live

   task automatic t_edge;
      irq_cfg[0].edge_select = 8'h02;
      irq_cfg[0].mask = 8'h04;
      det[0].signal_loss_flag = 1'b1;
      det[0].alarm_pattern_flag = 1'b1;
      det[0].driver_fault_flag = 1'b1;
      rd_chk(8'h18, 8'h03);
      det[0] = '0;
      @(negedge ref_clk);
      irq_chk(1'b1);
      host_addr = 8'h18;
      host_rd = 1'b1;
      @(negedge ref_clk);
      chk({rd_rsp.valid, rd_rsp.data}, 9'h102);
      @(negedge ref_clk);
      host_rd = 1'b0;
      chk({rd_rsp.valid, rd_rsp.data}, 9'h100);
      irq_chk(1'b0);
   endtask : t_edge

   task automatic t_race;
      @(negedge ref_clk);
      host_addr = 8'h18;
      host_rd = 1'b1;
      det[0].signal_loss_flag = 1'b1;
      @(negedge ref_clk);
      host_rd = 1'b0;
      chk({rd_rsp.valid, rd_rsp.data}, 9'h100);
      irq_chk(1'b1);
      rd_chk(8'h18, 8'h01);
      det[0].signal_loss_flag = 1'b0;
   endtask : t_race

   task automatic t_activate;
      for (int i = 0; i < 2; i++) begin
         auto_remote_loop_enable[0] = i[0];
         det[0].inband_activate_code = 1'b1;
         repeat ((i ? LONG_CYC : SHORT_CYC) - 4) @(negedge ref_clk);
         rd_chk(8'h16, 8'h00);
         repeat (8) @(negedge ref_clk);
         rd_chk(8'h16, 8'h40);
         rd_chk(8'h18, 8'h40);
         det[0].inband_activate_code = 1'b0;
         @(negedge ref_clk);
      end
   endtask : t_activate

   task automatic t_txloss;
      tx_run[0] <= 1'b0;
      repeat (60) @(negedge ref_clk);
      rd_chk(8'h16, 8'h00);
      repeat (20) @(negedge ref_clk);
      rd_chk(8'h16, 8'h08);
      rd_chk(8'h18, 8'h08);
      tx_run[0] <= 1'b1;
      repeat (8) @(negedge ref_clk);
      rd_chk(8'h16, 8'h00);
      irq_chk(1'b0);
   endtask : t_txloss

   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (16) @(negedge ref_clk);
      reset = 1'b0;
      t_reset_vals();
      t_live();
      t_edge();
      t_race();
      t_activate();
      t_txloss();
      end_sim();
   end
endmodule : tb_lsi_status_top
